/* rtl/srlw_top.sv */
// Purpose: Receive link configuration, SYNC control and link watchdog.
// Assumes: Link status and error strobes share this clock; APB slave.
// Notes: Registers are reached at byte address index * 4.
`timescale 1ns/1ps
`default_nettype none
module srlw_top #(
	parameter int LANES       = 16,
	parameter int WD_TICK_DIV = 8,
	parameter int LINK_DIV    = 4,
	parameter int TH1_LOG     = 17,
	parameter int TH2_LOG     = 19,
	parameter int TH3_LOG     = 21,
	parameter int TH4_LOG     = 23
) (
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             resetn,
	// APB slave
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [11:0]      paddr,
	input  wire logic [31:0]      pwdata,
	output logic                  pready,
	output logic [31:0]           prdata,
	output logic                  pslverr,
	// Link status from the receiver
	input  wire logic             link_up,
	input  wire logic             link_sync_n,
	input  wire logic             err_event,
	input  wire logic [LANES-1:0] mb_done,
	input  wire logic [LANES-1:0] mb_crc_err,
	// Configuration to the PHY
	output logic [3:0]            line_rate_mult_x2,
	output logic                  vco_low_range,
	output logic [2:0]            test_mode,
	output logic                  link_enable,
	output logic                  encoding_mode,
	// SYNC and PHY resets
	output logic                  sync_n,
	output logic                  phy_rx_reset,
	output logic                  phy_pll_reset,
	// Interrupt
	output logic                  irq
);
	localparam int WD_W  = TH4_LOG + 1;
	localparam int DIV_W = $clog2(WD_TICK_DIV);
	localparam int LNK_W = $clog2(LINK_DIV);

	generate
		if (LANES < 1 || LANES > 16 || WD_TICK_DIV < 2 || LINK_DIV < 2 ||
		    TH4_LOG > 30 || TH1_LOG < 1 || TH1_LOG > TH2_LOG ||
		    TH2_LOG > TH3_LOG || TH3_LOG > TH4_LOG)
			$error("srlw_top: unsupported parameter values");
	endgenerate

	function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
		return (a[1:0] == 2'b00) && (a[11:2] == idx);
	endfunction

	function automatic logic [3:0] rate_mult(input logic [1:0] code);
		case (code)
			2'b00:   return 4'h8;
			2'b01:   return 4'h4;
			2'b10:   return 4'h2;
			2'b11:   return 4'h1;
			default: return 4'h8;
		endcase
	endfunction

	function automatic logic [2:0] test_dec(input logic [4:0] code);
		return (code <= 5'h04) ? code[2:0] : srlw_pkg::SRLW_TEST_OFF;
	endfunction

	function automatic logic [WD_W-1:0] th_limit(input logic [2:0] code);
		case (code)
			3'h1:    return WD_W'(1) << TH1_LOG;
			3'h2:    return WD_W'(1) << TH2_LOG;
			3'h3:    return WD_W'(1) << TH3_LOG;
			3'h4:    return WD_W'(1) << TH4_LOG;
			default: return '0;
		endcase
	endfunction

	// Register storage
	logic [7:0] rate_code_r;
	logic [7:0] vco_low_range_bit_r;
	logic [7:0] sync_r;
	logic [7:0] test_r;
	logic [7:0] wdog_r;
	logic [7:0] epw_r;
	logic [7:0] crcth_r;
	logic [7:0] ctrl_r;
	logic [7:0] irq_stat;
	logic [7:0] irq_en;

	// APB decode
	wire setup  = psel & ~penable;
	wire wr_acc = psel & penable & pwrite & pready & ~pslverr;
	wire mapped = hit(paddr, srlw_pkg::IDX_RATE) |
		hit(paddr, srlw_pkg::IDX_VCO_LOW_RANGE_BIT) | hit(paddr, srlw_pkg::IDX_SYNC) |
		hit(paddr, srlw_pkg::IDX_TEST) | hit(paddr, srlw_pkg::IDX_WDOG) |
		hit(paddr, srlw_pkg::IDX_EPW) | hit(paddr, srlw_pkg::IDX_CRCTH) |
		hit(paddr, srlw_pkg::IDX_CTRL) | hit(paddr, srlw_pkg::IDX_STATUS) |
		hit(paddr, srlw_pkg::IDX_IRQ_STAT) |
		hit(paddr, srlw_pkg::IDX_IRQ_EN) | hit(paddr, srlw_pkg::IDX_IRQ_CLR);
	wire [7:0] wbyte = pwdata[7:0];
	wire [7:0] clr_bits = (wr_acc && hit(paddr, srlw_pkg::IDX_IRQ_CLR)) ?
		(wbyte & srlw_pkg::MASK_IRQ) : 8'h00;

	// Derived controls
	wire        manual_sync_request_bit = sync_r[0];
	wire [1:0]  watchdog_decrement_select = wdog_r[srlw_pkg::WD_DEC_LSB +: 2];
	wire [2:0]  watchdog_threshold_select = wdog_r[srlw_pkg::WD_TH_LSB +: 3];
	wire        watchdog_pll_reset_select = wdog_r[srlw_pkg::WD_PLL_BIT];
	wire [2:0]  error_pulse_width = epw_r[2:0];

	// Per-lane checksum faults
	logic [LANES-1:0] crc_fault;
	logic             fault_q;
	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			srlw_crc_lane u_lane (
				.clock     (clock),
				.resetn    (resetn),
				.mb_done   (mb_done[g]),
				.mb_err    (mb_crc_err[g]),
				.err_th    (crcth_r[srlw_pkg::CHECKSUM_ERROR_THRESHOLDS_LSB +: 2]),
				.rec_th    (crcth_r[srlw_pkg::CRC_REC_LSB +: 2]),
				.crc_fault (crc_fault[g])
			);
		end
	endgenerate
	wire fault_any = |crc_fault;

	// Watchdog; one tick per interval keeps the counter narrow
	logic [DIV_W-1:0] wd_div;
	logic [WD_W-1:0]  wd_count;
	logic [7:0]       rst_cnt;
	wire              wd_tick  = (wd_div == DIV_W'(WD_TICK_DIV - 1));
	wire [WD_W-1:0]   wd_limit = th_limit(watchdog_threshold_select);
	wire              wd_active = link_enable & (wd_limit != '0);
	wire              wd_fire  = wd_active & (wd_count >= wd_limit);
	wire              healthy  = link_up & ~fault_any;
	wire [WD_W-1:0]   wd_step  = (watchdog_decrement_select == 2'h0) ?
		WD_W'(1) : (watchdog_decrement_select == 2'h1) ? WD_W'(2) :
		(watchdog_decrement_select == 2'h2) ? WD_W'(8) : WD_W'(16);
	wire [WD_W-1:0]   wd_down  = (wd_count > wd_step) ?
		wd_count - wd_step : '0;
	wire [WD_W-1:0]   wd_up    = wd_count + WD_W'(1);
	// Sampling once per tick may miss brief link-up bursts
	wire [WD_W-1:0]   next_wd_count = (!wd_active || wd_fire) ? '0 :
		!wd_tick ? wd_count : healthy ? wd_down : wd_up;
	wire [7:0]        next_rst_cnt = wd_fire ?
		8'(srlw_pkg::PHY_RST_CYCLES) :
		(rst_cnt != 8'h00) ? rst_cnt - 8'h01 : 8'h00;

	// SYNC error pulse counted in link clock cycles
	logic [LNK_W-1:0] lnk_div;
	logic [2:0]       epw_cnt;
	wire              lnk_tick  = (lnk_div == LNK_W'(LINK_DIV - 1));
	wire              err_start = err_event & link_enable &
		(error_pulse_width != 3'h0) & (epw_cnt == 3'h0);
	wire [2:0]        next_epw_cnt = err_start ? error_pulse_width :
		(lnk_tick && epw_cnt != 3'h0) ? epw_cnt - 3'h1 : epw_cnt;
	wire              next_sync_n = manual_sync_request_bit &
		link_sync_n & (epw_cnt == 3'h0);

	// Interrupt status; a new event wins over a clear in the same cycle
	wire [7:0] irq_events = {5'h00, err_start, fault_any & ~fault_q, wd_fire};
	wire [7:0] next_irq_stat = (irq_stat & ~clr_bits) | irq_events;

	wire [7:0] status_word = {4'h0, |wd_count, fault_any, sync_n, link_up};
	wire [7:0] rd_byte =
		hit(paddr, srlw_pkg::IDX_RATE)     ? rate_code_r :
		hit(paddr, srlw_pkg::IDX_VCO_LOW_RANGE_BIT)   ? vco_low_range_bit_r :
		hit(paddr, srlw_pkg::IDX_SYNC)     ? sync_r :
		hit(paddr, srlw_pkg::IDX_TEST)     ? test_r :
		hit(paddr, srlw_pkg::IDX_WDOG)     ? wdog_r :
		hit(paddr, srlw_pkg::IDX_EPW)      ? epw_r :
		hit(paddr, srlw_pkg::IDX_CRCTH)    ? crcth_r :
		hit(paddr, srlw_pkg::IDX_CTRL)     ? ctrl_r :
		hit(paddr, srlw_pkg::IDX_STATUS)   ? status_word :
		hit(paddr, srlw_pkg::IDX_IRQ_STAT) ? irq_stat :
		hit(paddr, srlw_pkg::IDX_IRQ_EN)   ? irq_en : 8'h00;

	// Bus handshake: answer in the first access cycle
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~mapped;
			prdata  <= (setup && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0;
		end
	end

	// Masked writes drop reserved bits
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rate_code_r <= srlw_pkg::RST_RATE;
			vco_low_range_bit_r    <= srlw_pkg::RST_VCO_LOW_RANGE_BIT;
			sync_r      <= srlw_pkg::RST_SYNC;
			test_r      <= srlw_pkg::RST_TEST;
			wdog_r      <= srlw_pkg::RST_WDOG;
			epw_r       <= srlw_pkg::RST_EPW;
			crcth_r     <= srlw_pkg::RST_CRCTH;
			ctrl_r      <= srlw_pkg::RST_CTRL;
			irq_en      <= srlw_pkg::RST_IRQ;
		end else if (wr_acc) begin
			if (hit(paddr, srlw_pkg::IDX_RATE))
				rate_code_r <= wbyte & srlw_pkg::MASK_RATE;
			if (hit(paddr, srlw_pkg::IDX_VCO_LOW_RANGE_BIT))
				vco_low_range_bit_r <= wbyte & srlw_pkg::MASK_VCO_LOW_RANGE_BIT;
			if (hit(paddr, srlw_pkg::IDX_SYNC))
				sync_r <= wbyte & srlw_pkg::MASK_SYNC;
			if (hit(paddr, srlw_pkg::IDX_TEST))
				test_r <= wbyte & srlw_pkg::MASK_TEST;
			if (hit(paddr, srlw_pkg::IDX_WDOG))
				wdog_r <= wbyte & srlw_pkg::MASK_WDOG;
			if (hit(paddr, srlw_pkg::IDX_EPW))
				epw_r <= wbyte & srlw_pkg::MASK_EPW;
			if (hit(paddr, srlw_pkg::IDX_CRCTH))
				crcth_r <= wbyte & srlw_pkg::MASK_CRCTH;
			if (hit(paddr, srlw_pkg::IDX_CTRL))
				ctrl_r <= wbyte & srlw_pkg::MASK_CTRL;
			if (hit(paddr, srlw_pkg::IDX_IRQ_EN))
				irq_en <= wbyte & srlw_pkg::MASK_IRQ;
		end
	end

	// Registered configuration outputs
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			line_rate_mult_x2 <= 4'h8;
			vco_low_range     <= 1'b0;
			test_mode         <= srlw_pkg::SRLW_TEST_OFF;
			link_enable       <= 1'b0;
			encoding_mode     <= 1'b0;
		end else begin
			line_rate_mult_x2 <= rate_mult(rate_code_r[1:0]);
			vco_low_range     <= vco_low_range_bit_r[0];
			test_mode         <= test_dec(test_r[4:0]);
			link_enable       <= ctrl_r[srlw_pkg::CTRL_EN_BIT];
			encoding_mode     <= ctrl_r[srlw_pkg::CTRL_ENC_BIT];
		end
	end

	// Watchdog, SYNC and interrupt state
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wd_div        <= '0;
			wd_count      <= '0;
			rst_cnt       <= 8'h00;
			phy_rx_reset  <= 1'b0;
			phy_pll_reset <= 1'b0;
			lnk_div       <= '0;
			epw_cnt       <= 3'h0;
			sync_n        <= 1'b0;
			fault_q       <= 1'b0;
			irq_stat      <= srlw_pkg::RST_IRQ;
			irq           <= 1'b0;
		end else begin
			wd_div        <= wd_tick ? '0 : wd_div + DIV_W'(1);
			wd_count      <= next_wd_count;
			rst_cnt       <= next_rst_cnt;
			phy_rx_reset  <= next_rst_cnt != 8'h00;
			if (wd_fire)
				phy_pll_reset <= watchdog_pll_reset_select;
			else if (next_rst_cnt == 8'h00)
				phy_pll_reset <= 1'b0;
			lnk_div       <= lnk_tick ? '0 : lnk_div + LNK_W'(1);
			epw_cnt       <= next_epw_cnt;
			sync_n        <= next_sync_n;
			fault_q       <= fault_any;
			irq_stat      <= next_irq_stat;
			irq           <= |(irq_stat & irq_en);
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	a_rate_mult: assert property (
		1'b1 |=> line_rate_mult_x2 == rate_mult($past(rate_code_r[1:0])))
		else $error("line rate multiplier does not follow code");
	a_manual_sync: assert property (
		!manual_sync_request_bit |=> !sync_n)
		else $error("manual request did not assert sync");
	a_test_reserved: assert property (
		test_r[4:0] > 5'h04 |=> test_mode == srlw_pkg::SRLW_TEST_OFF)
		else $error("reserved test code not treated as off");
	a_wdog_pll: assert property (
		wd_fire |=> phy_rx_reset && phy_pll_reset == $past(wdog_r[7]))
		else $error("expiry reset selection wrong");
	a_wdog_clear: assert property (
		wd_fire |=> wd_count == '0 ##1 phy_rx_reset)
		else $error("watchdog did not reset after expiry");
	a_wdog_dec: assert property (
		wd_active && !wd_fire && wd_tick && healthy && wd_count > wd_step
		|=> wd_count == $past(wd_count) - $past(wd_step))
		else $error("watchdog decrement step wrong");
	a_wdog_inc: assert property (
		wd_active && !wd_fire && wd_tick && !healthy
		|=> wd_count == $past(wd_count) + WD_W'(1))
		else $error("watchdog did not advance");
	a_wdog_off: assert property (
		watchdog_threshold_select == 3'h0 |=> wd_count == '0)
		else $error("disabled watchdog counted");
	a_err_pulse: assert property (
		err_start |=> ##1 !sync_n)
		else $error("error report did not assert sync");
	a_epw_zero: assert property (
		error_pulse_width == 3'h0 && epw_cnt == 3'h0 && link_sync_n &&
		manual_sync_request_bit |=> sync_n)
		else $error("sync asserted with reporting disabled");
	a_irq_level: assert property (
		|(irq_stat & irq_en) |=> irq)
		else $error("interrupt not raised");

endmodule // srlw_top
`default_nettype wire

/* rtl/srlw_pkg.sv */
// Purpose: Shared constants for the serial receive link control block.
// Assumes: Register indices are word indices; byte address is index * 4.
// Notes: Only bits named by a mask are stored; all other bits read zero.
package srlw_pkg;

	// Register word indices
	localparam logic [9:0] IDX_RATE     = 10'h10a;
	localparam logic [9:0] IDX_VCO_LOW_RANGE_BIT   = 10'h10b;
	localparam logic [9:0] IDX_SYNC     = 10'h120;
	localparam logic [9:0] IDX_TEST     = 10'h121;
	localparam logic [9:0] IDX_WDOG     = 10'h124;
	localparam logic [9:0] IDX_EPW      = 10'h127;
	localparam logic [9:0] IDX_CRCTH    = 10'h128;
	localparam logic [9:0] IDX_CTRL     = 10'h180;
	localparam logic [9:0] IDX_STATUS   = 10'h181;
	localparam logic [9:0] IDX_IRQ_STAT = 10'h182;
	localparam logic [9:0] IDX_IRQ_EN   = 10'h183;
	localparam logic [9:0] IDX_IRQ_CLR  = 10'h184;

	// Writable bits of each register
	localparam logic [7:0] MASK_RATE   = 8'h03;
	localparam logic [7:0] MASK_VCO_LOW_RANGE_BIT = 8'h01;
	localparam logic [7:0] MASK_SYNC   = 8'h01;
	localparam logic [7:0] MASK_TEST   = 8'h1f;
	localparam logic [7:0] MASK_WDOG   = 8'hb7;
	localparam logic [7:0] MASK_EPW    = 8'h07;
	localparam logic [7:0] MASK_CRCTH  = 8'h0f;
	localparam logic [7:0] MASK_CTRL   = 8'h03;
	localparam logic [7:0] MASK_IRQ    = 8'h07;

	// Reset values
	localparam logic [7:0] RST_RATE   = 8'h00;
	localparam logic [7:0] RST_VCO_LOW_RANGE_BIT = 8'h00;
	localparam logic [7:0] RST_SYNC   = 8'h01;
	localparam logic [7:0] RST_TEST   = 8'h00;
	localparam logic [7:0] RST_WDOG   = 8'h00;
	localparam logic [7:0] RST_EPW    = 8'h00;
	localparam logic [7:0] RST_CRCTH  = 8'h00;
	localparam logic [7:0] RST_CTRL   = 8'h00;
	localparam logic [7:0] RST_IRQ    = 8'h00;

	// Field positions
	localparam int WD_PLL_BIT  = 7;
	localparam int WD_DEC_LSB  = 4;
	localparam int WD_TH_LSB   = 0;
	localparam int CRC_REC_LSB = 2;
	localparam int CHECKSUM_ERROR_THRESHOLDS_LSB  = 0;
	localparam int CTRL_EN_BIT  = 0;
	localparam int CTRL_ENC_BIT = 1;
	localparam int IRQ_WDOG = 0;
	localparam int IRQ_CRC  = 1;
	localparam int IRQ_ERR  = 2;

	// Timing
	localparam int CLK_MHZ        = 100;
	localparam int PHY_RST_NS     = 160;
	localparam int PHY_RST_CYCLES = (PHY_RST_NS * CLK_MHZ + 999) / 1000;

	typedef enum logic [2:0] {
		SRLW_TEST_OFF    = 3'b000,
		SRLW_TEST_PRBS7  = 3'b001,
		SRLW_TEST_PRBS9  = 3'b010,
		SRLW_TEST_PRBS15 = 3'b011,
		SRLW_TEST_PRBS31 = 3'b100
	} srlw_test_t;

endpackage

/* rtl/srlw_crc_lane.sv */
// Purpose: Per-lane checksum fault tracker over received multiblocks.
// Assumes: Multiblock strobes come from logic on the same clock.
// Notes: Fault sets when the error count reaches the threshold.
`timescale 1ns/1ps
`default_nettype none
module srlw_crc_lane (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       resetn,
	// Multiblock events
	input  wire logic       mb_done,
	input  wire logic       mb_err,
	// Thresholds
	input  wire logic [1:0] err_th,
	input  wire logic [1:0] rec_th,
	// Result
	output logic            crc_fault
);
	logic [3:0] err_cnt;
	logic [6:0] clean_cnt;

	wire [3:0] err_lim   = 4'(4'h1 << err_th);
	wire [6:0] clean_lim = 7'(7'h01 << {rec_th, 1'b0});
	wire [3:0] err_inc   = (err_cnt == err_lim) ? err_cnt : err_cnt + 4'h1;
	wire [6:0] clean_inc = clean_cnt + 7'h01;
	wire       recovered = mb_done & ~mb_err & (clean_inc >= clean_lim);

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			err_cnt   <= 4'h0;
			clean_cnt <= 7'h00;
			crc_fault <= 1'b0;
		end else if (mb_done && mb_err) begin
			err_cnt   <= err_inc;
			clean_cnt <= 7'h00;
			if (err_inc >= err_lim)
				crc_fault <= 1'b1;
		end else if (recovered) begin
			err_cnt   <= 4'h0;
			clean_cnt <= 7'h00;
			crc_fault <= 1'b0;
		end else if (mb_done) begin
			clean_cnt <= clean_inc;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	a_crc_recover: assert property (
		recovered |=> !crc_fault && err_cnt == 4'h0)
		else $error("fault not cleared after clean run");
	a_crc_trigger: assert property (
		mb_done && mb_err && err_inc >= err_lim |=> crc_fault)
		else $error("fault not set at error threshold");

endmodule // srlw_crc_lane
`default_nettype wire

/* sim/srlw_tx_model.sv */
// Purpose: Far-end transmitter and receiver front end for the link block.
// Assumes: Bench controls change on the block clock.
// Notes: Link comes up 1 to 4 cycles after requested, so waits vary.
`timescale 1ns/1ps
`default_nettype none
module srlw_tx_model #(
	parameter int LANES = 16
) (
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             resetn,
	// Bench controls
	input  wire logic             want_up,
	input  wire logic [LANES-1:0] bad_crc,
	input  wire logic             fire_err,
	// Towards the block
	output logic                  link_up,
	output logic                  link_sync_n,
	output logic                  err_event,
	output logic [LANES-1:0]      mb_done,
	output logic [LANES-1:0]      mb_crc_err
);
	logic [3:0] mb_cnt;
	logic [1:0] lag;
	logic       mb_tick;

	assign mb_tick = link_up && (mb_cnt == 4'h0);

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			link_up     <= 1'b0;
			link_sync_n <= 1'b0;
			err_event   <= 1'b0;
			mb_cnt      <= 4'h0;
			lag         <= 2'h0;
			mb_done     <= '0;
			mb_crc_err  <= '0;
		end else begin
			// Up means the elastic buffer was released
			if (!want_up) begin
				link_up <= 1'b0;
				lag     <= 2'($urandom_range(3));
			end else if (lag != 2'h0) begin
				lag <= lag - 2'h1;
			end else begin
				link_up <= 1'b1;
			end
			// Resync is requested until the link is up
			link_sync_n <= link_up;
			err_event   <= fire_err && link_up;
			mb_cnt      <= mb_cnt + 4'h1;
			mb_done     <= {LANES{mb_tick}};
			mb_crc_err  <= {LANES{mb_tick}} & bad_crc;
		end
	end
endmodule // srlw_tx_model
`default_nettype wire

/* sim/srlw_tb.sv */
// Purpose: Self-checking bench for the receive link control block.
// Assumes: Short watchdog limits (2^3..2^6 ticks) stand in for the real ones.
// Notes: Config other than SYNC and IRQ_EN is only touched with the link disabled.
`timescale 1ns/1ps
`default_nettype none
module serial_rx_link_control_watchdog_tb;
	localparam int TD = 8;
	localparam int LD = 4;
	logic        clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rdv;
	logic        pready, pslverr, rerr, link_up, link_sync_n, err_event;
	logic [3:0]  mb_done, mb_crc_err, mult;
	logic        vco, link_en, enc, sync_n, rx_rst, pll_rst, irq;
	logic [2:0]  test_mode;
	logic        want_up = 0, fire_err = 0;
	logic [3:0]  bad_crc = '0;
	logic [1:0]  pofs = '0;
	int          num_errors = 0, checked = 0, t, h;

	always #5 clock = ~clock;

	srlw_top #(.LANES(4), .WD_TICK_DIV(TD), .LINK_DIV(LD), .TH1_LOG(3),
		.TH2_LOG(4), .TH3_LOG(5), .TH4_LOG(6)) dut (.clock(clock),
		.resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .link_up(link_up), .link_sync_n(link_sync_n),
		.err_event(err_event), .mb_done(mb_done), .mb_crc_err(mb_crc_err),
		.line_rate_mult_x2(mult), .vco_low_range(vco),
		.test_mode(test_mode), .link_enable(link_en),
		.encoding_mode(enc), .sync_n(sync_n), .phy_rx_reset(rx_rst),
		.phy_pll_reset(pll_rst), .irq(irq));

	srlw_tx_model #(.LANES(4)) far (.clock(clock), .resetn(resetn),
		.want_up(want_up), .bad_crc(bad_crc), .fire_err(fire_err),
		.link_up(link_up), .link_sync_n(link_sync_n),
		.err_event(err_event), .mb_done(mb_done), .mb_crc_err(mb_crc_err));

	function automatic logic [3:0] exp_mult(input logic [1:0] c);
		return 4'h8 >> c;
	endfunction
	function automatic logic [2:0] exp_test(input logic [4:0] v);
		return (v <= 5'h04) ? v[2:0] : 3'h0;
	endfunction
	function automatic int exp_lim(input int c);
		return (c >= 1 && c <= 4) ? (1 << (c + 2)) : 0;
	endfunction

	task automatic stop_test;
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rng(input string n, input int lo, input int hi,
		input int g);
		checked++;
		if (g < lo || g > hi) begin
			num_errors++;
			$display("FAIL %s expected %0d..%0d seen %0d", n, lo, hi, g);
		end
	endtask
	task automatic apb(input logic w, input logic [9:0] idx,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, pofs};
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		// Ready and read data are both taken at the completing edge
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rdv = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 20)
			chk("pready", 1, 0);
	endtask
	task automatic settle;
		repeat (2) @(posedge clock);
	endtask
	task automatic cfg(input logic [9:0] idx, input logic [31:0] d);
		apb(1, srlw_pkg::IDX_CTRL, 0);
		apb(1, idx, d);
	endtask
	task automatic wait_rst(input int lim);
		t = 0;
		while (rx_rst !== 1'b1 && t < lim) begin
			@(posedge clock);
			t++;
		end
	endtask
	task automatic pulse_err;
		@(posedge clock);
		fire_err <= 1'b1;
		@(posedge clock);
		fire_err <= 1'b0;
	endtask

	initial begin
		logic [9:0] ri[7];
		logic [7:0] rv[7];
		int v, w, lim;
		logic p;
		ri = '{srlw_pkg::IDX_RATE, srlw_pkg::IDX_VCO_LOW_RANGE_BIT, srlw_pkg::IDX_SYNC,
			srlw_pkg::IDX_TEST, srlw_pkg::IDX_WDOG, srlw_pkg::IDX_EPW,
			srlw_pkg::IDX_CRCTH};
		rv = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
		void'($urandom(32'ha4de1e4f));
		repeat (4) @(posedge clock);
		resetn <= 1'b1;
		settle();
		for (int i = 0; i < 7; i++) begin
			apb(0, ri[i], 0);
			chk("reset_value", {24'h0, rv[i]}, rdv);
		end
		chk("reset_mult", 4'h8, mult);
		$display("test reset done");
		for (int c = 0; c < 4; c++) begin
			v = ($urandom() & 32'hfffffffc) | c;
			cfg(srlw_pkg::IDX_RATE, v);
			settle();
			chk("rate_mult", exp_mult(c[1:0]), mult);
			apb(0, srlw_pkg::IDX_RATE, 0);
			chk("rate_read", c, rdv);
		end
		for (int i = 0; i < 12; i++) begin
			v = (i < 8) ? i : $urandom_range(31);
			cfg(srlw_pkg::IDX_TEST, v);
			settle();
			chk("test_mode", exp_test(v[4:0]), test_mode);
		end
		cfg(srlw_pkg::IDX_VCO_LOW_RANGE_BIT, 32'h000000ff);
		settle();
		chk("vco_low", 1, vco);
		apb(0, 10'h3ff, 0);
		chk("unmapped_err", 1, rerr);
		chk("unmapped_data", 0, rdv);
		pofs = 2'b10;
		apb(1, srlw_pkg::IDX_RATE, 0);
		chk("unaligned_err", 1, rerr);
		pofs = 2'b00;
		apb(0, srlw_pkg::IDX_RATE, 0);
		chk("unaligned_kept", 3, rdv);
		apb(1, srlw_pkg::IDX_CTRL, 2);
		settle();
		chk("encoding_mode", 2'b10, {enc, link_en});
		apb(1, srlw_pkg::IDX_CTRL, 1);
		settle();
		chk("link_enable", 2'b01, {enc, link_en});
		$display("test config done");
		want_up <= 1'b1;
		repeat (20) @(posedge clock);
		chk("sync_idle", 1, sync_n);
		apb(1, srlw_pkg::IDX_SYNC, 0);
		settle();
		chk("sync_manual", 0, sync_n);
		apb(1, srlw_pkg::IDX_SYNC, 1);
		settle();
		chk("sync_release", 1, sync_n);
		foreach (rv[i]) begin
			w = (i == 0) ? 0 : (i == 1) ? 7 : $urandom_range(1, 7);
			cfg(srlw_pkg::IDX_EPW, w);
			apb(1, srlw_pkg::IDX_CTRL, 1);
			pulse_err();
			h = 0;
			repeat (60) begin
				@(posedge clock);
				h += (sync_n === 1'b0);
			end
			rng("sync_err_low", (w == 0) ? 0 : (w - 1) * LD,
				(w == 0) ? 0 : (w + 1) * LD, h);
		end
		$display("test sync done");
		want_up <= 1'b0;
		apb(1, srlw_pkg::IDX_IRQ_EN, 1);
		for (int c = 0; c < 8; c++) begin
			p = 1'($urandom_range(1));
			cfg(srlw_pkg::IDX_WDOG, {p, 3'($urandom_range(3)), 1'b0, 3'(c)});
			apb(1, srlw_pkg::IDX_CTRL, 1);
			lim = exp_lim(c);
			wait_rst(700);
			if (lim == 0) begin
				chk("wdog_off", 700, t);
			end else begin
				rng("wdog_fire", lim * TD - TD, lim * TD + TD, t);
				chk("pll_reset", p, pll_rst);
				h = 0;
				while (rx_rst === 1'b1 && h < 40) begin
					@(posedge clock);
					h++;
				end
				chk("rx_reset_len", srlw_pkg::PHY_RST_CYCLES, h);
			end
		end
		apb(1, srlw_pkg::IDX_CTRL, 0);
		chk("irq_set", 1, irq);
		apb(0, srlw_pkg::IDX_IRQ_STAT, 0);
		chk("irq_stat", 1, rdv & 1);
		apb(1, srlw_pkg::IDX_IRQ_EN, 0);
		settle();
		chk("irq_masked", 0, irq);
		apb(1, srlw_pkg::IDX_IRQ_CLR, 1);
		apb(0, srlw_pkg::IDX_IRQ_STAT, 0);
		chk("irq_cleared", 0, rdv & 1);
		resetn <= 1'b0;
		repeat (2) @(posedge clock);
		resetn <= 1'b1;
		apb(0, srlw_pkg::IDX_WDOG, 0);
		chk("mid_reset_wdog", 0, rdv);
		chk("mid_reset_sync", 0, sync_n);
		$display("test watchdog done");
		want_up <= 1'b1;
		cfg(srlw_pkg::IDX_CRCTH, 0);
		cfg(srlw_pkg::IDX_WDOG, {2'b00, 2'($urandom_range(3)), 4'h1});
		apb(1, srlw_pkg::IDX_CTRL, 1);
		wait_rst(400);
		chk("healthy_hold", 400, t);
		bad_crc <= 4'($urandom_range(1, 15));
		wait_rst(400);
		chk("crc_fault_reset", 1, rx_rst);
		apb(0, srlw_pkg::IDX_STATUS, 0);
		chk("crc_fault_flag", 4, rdv & 4);
		$display("test health done");
		stop_test();
	end

	initial begin
		repeat (50000) @(posedge clock);
		num_errors++;
		stop_test();
	end
endmodule // serial_rx_link_control_watchdog_tb
`default_nettype wire
